/* File: rtl/tbg_pkg.sv */
// package for the three-bank gpio block: register map, field layout,
// reset values and interrupt polarity encodings.
// assumes a byte-wide register port with byte addresses.
package tbg_pkg;
    // ========================================
    // widths
    localparam int TBG_NPIN = 8;
    localparam int TBG_NBANK = 3;
    localparam int TBG_NALL = 24;
    localparam int TBG_ADDR_W = 8;
    localparam int TBG_NGRP = 2;

    // ========================================
    // register offsets
    localparam logic [7:0] TBG_BASE_A = 8'h08;
    localparam logic [7:0] TBG_BASE_B = 8'h04;
    localparam logic [7:0] TBG_BASE_C = 8'h00;
    localparam logic [7:0] TBG_SUB_VALUE = 8'h00;
    localparam logic [7:0] TBG_SUB_DIR = 8'h01;
    localparam logic [7:0] TBG_SUB_MODE = 8'h02;
    localparam logic [7:0] TBG_OFF_IRQ_POL = 8'h0c;

    // ========================================
    // bank indices and reset values
    localparam int TBG_BANK_A = 0;
    localparam int TBG_BANK_B = 1;
    localparam int TBG_BANK_C = 2;
    localparam logic [7:0] TBG_RST_VALUE = 8'h00;
    localparam logic [7:0] TBG_RST_DIR = 8'h00;
    localparam logic [7:0] TBG_RST_MODE = 8'h00;
    localparam logic [3:0] TBG_RST_POL = 4'h0;
    localparam int TBG_POL0_LSB = 0;
    localparam int TBG_POL1_LSB = 2;

    // ========================================
    // interrupt polarity choices
    typedef enum logic [1:0] {
        TBG_POL_FALL_LOW = 2'b00,
        TBG_POL_RISE = 2'b01,
        TBG_POL_FALL = 2'b10,
        TBG_POL_BOTH = 2'b11
    } tbg_pol_e;
endpackage

/* File: rtl/tbg_irq_if.sv */
// interface between the gpio core and one interrupt group detector.
// assumes both ends run on core_clk.
`timescale 1ns/10ps
interface tbg_irq_if;
    import tbg_pkg::*;
    logic level;
    tbg_pol_e pol;
    logic pol_wr;
    logic ack;
    logic req;
    modport core (output level, output pol, output pol_wr, output ack,
        input req);
    modport det (input level, input pol, input pol_wr, input ack,
        output req);
endinterface

/* File: rtl/tbg_irq_det.sv */
// edge/level detector and request latch for one interrupt group.
// assumes the combined group level is already synchronised.
`timescale 1ns/10ps
module tbg_irq_det import tbg_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // group link
    tbg_irq_if.det grp
);
    logic prev_q;
    logic req_q;
    logic evt;

    // ========================================
    // event detection
    always_comb begin
        case (grp.pol)
            TBG_POL_FALL_LOW: evt = ~grp.level;
            TBG_POL_FALL: evt = prev_q & ~grp.level;
            TBG_POL_RISE: evt = ~prev_q & grp.level;
            TBG_POL_BOTH: evt = prev_q ^ grp.level;
            default: evt = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= grp.level;
        end
    end

    // ========================================
    // request latch: a new event beats ack or a polarity change
    always_ff @(posedge core_clk) begin
        if (srst) begin
            req_q <= 1'b0;
        end else if (evt) begin
            req_q <= 1'b1;
        end else if (grp.ack || grp.pol_wr) begin
            req_q <= 1'b0;
        end
    end

    assign grp.req = req_q;
endmodule // tbg_irq_det

/* File: rtl/tbg_gpio.sv */
// three-bank gpio core: registers, pin drivers, alternate functions and
// external interrupt grouping.
// assumes pins arrive asynchronously and peripherals run on core_clk.
//
// What this block does
// - each bank has eight bits; bit x of every register controls pin x
// - direction resets to zero; zero is input, one is output
// - reading an input pin returns the live pin level
// - output pins drive the latch and read back the latch
// - writes always update the latch, even for input pins
// - input-with-interrupt pins raise a request on the selected event
// - pins of one interrupt group are anded before detection
// - output pins never generate interrupts
// - a claiming peripheral overrides pin settings and drives it
// - peripheral input pins stay readable through the value register
// - bank a: option selects interrupt input; register output is open drain, but a push-pull peripheral claim enables the p-driver
// - banks b, c: option selects pull-up interrupt or push-pull
// - p-driver only in push-pull; pull-up only in pull-up input
// - option register resets to zero, floating inputs
// - without option register, direction alone sets the pin
// - polarity picks fall+low, fall, rise or both; fall+low at reset
`timescale 1ns/10ps
module tbg_gpio import tbg_pkg::*; #(
    parameter int BANK_C_PINS = 6,
    parameter logic [2:0] OPT_PRESENT = 3'b111,
    parameter logic [23:0] EI1_MAP = 24'hffff00
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // bank a pins
    input wire logic [7:0] bank_a_pins_in,
    output logic [7:0] bank_a_pins_out,
    output logic [7:0] bank_a_pins_oe,
    output logic [7:0] bank_a_pull_en,
    output logic [7:0] bank_a_p_drive_en,
    // bank b pins
    input wire logic [7:0] bank_b_pins_in,
    output logic [7:0] bank_b_pins_out,
    output logic [7:0] bank_b_pins_oe,
    output logic [7:0] bank_b_pull_en,
    output logic [7:0] bank_b_p_drive_en,
    // bank c pins
    input wire logic [BANK_C_PINS-1:0] bank_c_pins_in,
    output logic [BANK_C_PINS-1:0] bank_c_pins_out,
    output logic [BANK_C_PINS-1:0] bank_c_pins_oe,
    output logic [BANK_C_PINS-1:0] bank_c_pull_en,
    output logic [BANK_C_PINS-1:0] bank_c_p_drive_en,
    // peripheral alternate functions, index bank*8+pin
    input wire logic [23:0] alt_claim,
    input wire logic [23:0] alt_value,
    input wire logic [23:0] alt_push_pull,
    output logic [23:0] alt_pin_level,
    // external interrupt requests
    input wire logic [1:0] irq_ack,
    output logic [1:0] irq_req
);
    // ========================================
    // elaboration checks
    if (BANK_C_PINS < 1 || BANK_C_PINS > TBG_NPIN) begin : g_chk
        $error("bank c pin count must be 1 to 8");
    end

    // ========================================
    // declarations
    logic [7:0] value_bits_q [TBG_NBANK];
    logic [7:0] direction_bits_q [TBG_NBANK];
    logic [7:0] config_bits_q [TBG_NBANK];
    logic [3:0] pol_q;
    logic [7:0] rdata_q;
    logic [23:0] pin_raw;
    logic [23:0] sync1_q;
    logic [23:0] sync2_q;
    logic [23:0] present;
    logic [23:0] drv_out;
    logic [23:0] drv_oe;
    logic [23:0] drv_pull;
    logic [23:0] drv_p;
    logic [23:0] irq_sel;
    logic [23:0] read_bits;
    logic [1:0] grp_level;
    logic pol_hit;

    // ========================================
    // address decode
    function automatic logic [7:0] bank_base(input int b);
        case (b)
            TBG_BANK_A: bank_base = TBG_BASE_A;
            TBG_BANK_B: bank_base = TBG_BASE_B;
            default: bank_base = TBG_BASE_C;
        endcase
    endfunction

    function automatic logic hit(input logic [7:0] addr, input int b,
        input logic [7:0] sub);
        hit = (addr == (bank_base(b) + sub));
    endfunction

    // ========================================
    // register writes
    always_ff @(posedge core_clk) begin
        for (int b = 0; b < TBG_NBANK; b++) begin
            if (srst) begin
                value_bits_q[b] <= TBG_RST_VALUE;
            end else if (reg_wr && hit(reg_addr, b, TBG_SUB_VALUE)) begin
                value_bits_q[b] <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        for (int b = 0; b < TBG_NBANK; b++) begin
            if (srst) begin
                direction_bits_q[b] <= TBG_RST_DIR;
            end else if (reg_wr && hit(reg_addr, b, TBG_SUB_DIR)) begin
                direction_bits_q[b] <= reg_wdata;
            end
        end
    end

    // a bank without an option register keeps it at zero
    always_ff @(posedge core_clk) begin
        for (int b = 0; b < TBG_NBANK; b++) begin
            if (srst || !OPT_PRESENT[b]) begin
                config_bits_q[b] <= TBG_RST_MODE;
            end else if (reg_wr && hit(reg_addr, b, TBG_SUB_MODE)) begin
                config_bits_q[b] <= reg_wdata;
            end
        end
    end

    assign pol_hit = reg_wr && (reg_addr == TBG_OFF_IRQ_POL);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pol_q <= TBG_RST_POL;
        end else if (pol_hit) begin
            pol_q <= reg_wdata[3:0];
        end
    end

    // ========================================
    // pin synchroniser
    assign pin_raw = {{(TBG_NPIN-BANK_C_PINS){1'b0}}, bank_c_pins_in,
        bank_b_pins_in, bank_a_pins_in};
    assign present = {{(TBG_NPIN-BANK_C_PINS){1'b0}}, {BANK_C_PINS{1'b1}},
        16'hffff};

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync1_q <= 24'h000000;
            sync2_q <= 24'h000000;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    assign alt_pin_level = sync2_q & present;

    // ========================================
    // per-pin mode decode
    always_comb begin
        drv_out = 24'h000000;
        drv_oe = 24'h000000;
        drv_pull = 24'h000000;
        drv_p = 24'h000000;
        irq_sel = 24'h000000;
        read_bits = 24'h000000;
        for (int i = 0; i < TBG_NALL; i++) begin
            automatic int b = i / TBG_NPIN;
            automatic int k = i % TBG_NPIN;
            automatic logic d = direction_bits_q[b][k];
            automatic logic o = config_bits_q[b][k];
            automatic logic l = value_bits_q[b][k];
            if (alt_claim[i]) begin
                // peripheral wins over register settings
                drv_oe[i] = alt_push_pull[i] | ~alt_value[i];
                drv_out[i] = alt_push_pull[i] & alt_value[i];
                drv_p[i] = alt_push_pull[i];
            end else if (d) begin
                if (b != TBG_BANK_A && o) begin
                    drv_oe[i] = 1'b1;
                    drv_out[i] = l;
                    drv_p[i] = 1'b1;
                end else begin
                    // open drain; bank a reserved option also lands here
                    drv_oe[i] = ~l;
                    drv_out[i] = 1'b0;
                end
            end else begin
                drv_pull[i] = (b != TBG_BANK_A) && o;
                irq_sel[i] = o;
            end
            read_bits[i] = d ? l : sync2_q[i];
        end
        drv_out = drv_out & present;
        drv_oe = drv_oe & present;
        drv_pull = drv_pull & present;
        drv_p = drv_p & present;
        irq_sel = irq_sel & present;
        read_bits = read_bits & present;
    end

    assign bank_a_pins_out = drv_out[7:0];
    assign bank_a_pins_oe = drv_oe[7:0];
    assign bank_a_pull_en = drv_pull[7:0];
    assign bank_a_p_drive_en = drv_p[7:0];
    assign bank_b_pins_out = drv_out[15:8];
    assign bank_b_pins_oe = drv_oe[15:8];
    assign bank_b_pull_en = drv_pull[15:8];
    assign bank_b_p_drive_en = drv_p[15:8];
    assign bank_c_pins_out = drv_out[16 +: BANK_C_PINS];
    assign bank_c_pins_oe = drv_oe[16 +: BANK_C_PINS];
    assign bank_c_pull_en = drv_pull[16 +: BANK_C_PINS];
    assign bank_c_p_drive_en = drv_p[16 +: BANK_C_PINS];

    // ========================================
    // interrupt groups
    // one low member holds the whole group low and hides the others
    assign grp_level[0] = &(sync2_q | ~(irq_sel & ~EI1_MAP));
    assign grp_level[1] = &(sync2_q | ~(irq_sel & EI1_MAP));

    tbg_irq_if grp_if [TBG_NGRP] ();

    for (genvar g = 0; g < TBG_NGRP; g++) begin : g_grp
        assign grp_if[g].level = grp_level[g];
        assign grp_if[g].pol = tbg_pol_e'(pol_q[2*g +: 2]);
        assign grp_if[g].pol_wr = pol_hit &&
            (reg_wdata[2*g +: 2] != pol_q[2*g +: 2]);
        assign grp_if[g].ack = irq_ack[g];
        assign irq_req[g] = grp_if[g].req;
        tbg_irq_det u_det (
            .core_clk(core_clk),
            .srst(srst),
            .grp(grp_if[g])
        );
    end

    // ========================================
    // register reads, one cycle latency, unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= 8'h00;
            for (int b = 0; b < TBG_NBANK; b++) begin
                if (hit(reg_addr, b, TBG_SUB_VALUE)) begin
                    rdata_q <= read_bits[b*TBG_NPIN +: TBG_NPIN];
                end
                if (hit(reg_addr, b, TBG_SUB_DIR)) begin
                    rdata_q <= direction_bits_q[b];
                end
                if (hit(reg_addr, b, TBG_SUB_MODE)) begin
                    rdata_q <= config_bits_q[b];
                end
            end
            if (reg_addr == TBG_OFF_IRQ_POL) begin
                rdata_q <= {4'h0, pol_q};
            end
        end
    end

    assign reg_rdata = rdata_q;
endmodule // tbg_gpio

/* File: verif/tbg_gpio_monitor.sv */
// concurrent checks on the gpio core, top-level ports only.
// assumes one core_clk domain, srst synchronous and active high.
`timescale 1ns/10ps
module tbg_gpio_chk import tbg_pkg::*; #(
    parameter int BANK_C_PINS = 6
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic [7:0] bank_a_pins_in,
    input wire logic [7:0] bank_a_pins_oe,
    input wire logic [7:0] bank_a_pull_en,
    input wire logic [7:0] bank_a_p_drive_en,
    input wire logic [7:0] bank_b_pins_out,
    input wire logic [7:0] bank_b_pins_oe,
    input wire logic [7:0] bank_b_pull_en,
    input wire logic [7:0] bank_b_p_drive_en,
    input wire logic [BANK_C_PINS-1:0] bank_c_pins_oe,
    // peripherals and interrupts
    input wire logic [23:0] alt_claim,
    input wire logic [23:0] alt_value,
    input wire logic [23:0] alt_push_pull,
    input wire logic [23:0] alt_pin_level,
    input wire logic [1:0] irq_ack,
    input wire logic [1:0] irq_req
);
    // ========================================
    // helpers
    wire logic [7:0] pp_a = alt_claim[7:0] & alt_push_pull[7:0];
    wire logic [7:0] od_a = alt_claim[7:0] & ~alt_push_pull[7:0];
    wire logic [7:0] pp_b = alt_claim[15:8] & alt_push_pull[15:8];
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    sequence s_hole_read;
        reg_rd && (reg_addr > 8'h0c || reg_addr[1:0] == 2'b11);
    endsequence
    // the synchroniser is cleared by reset, so wait two clean edges
    sequence s_sync_run;
        !$past(srst) && !$past(srst, 2);
    endsequence

    // ========================================
    // assertions
    AST_HOLE_READ: assert property (
        s_hole_read |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RESET_IDLE: assert property (
        $fell(srst) && alt_claim == 24'h0
        |-> (bank_a_pins_oe | bank_b_pins_oe | bank_b_pull_en) == 8'h00
        && bank_c_pins_oe == '0) else $error("pin driven after reset");
    AST_A_NO_PUSH: assert property (
        ((bank_a_p_drive_en & ~pp_a) | bank_a_pull_en) == 8'h00)
        else $error("bank a p-driver on");
    AST_PULL_IN: assert property (
        (bank_b_pull_en & bank_b_pins_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    AST_OD_HIGH: assert property (
        (bank_b_pins_oe & ~bank_b_p_drive_en & bank_b_pins_out) == 8'h00)
        else $error("open drain drives high");
    AST_ALT_PP: assert property (
        (pp_b & ~(bank_b_pins_oe & bank_b_p_drive_en
        & ~(bank_b_pins_out ^ alt_value[15:8]))) == 8'h00)
        else $error("push-pull claim not driven");
    AST_ALT_OD: assert property (
        (od_a & (bank_a_pins_oe ^ ~alt_value[7:0])) == 8'h00)
        else $error("open drain claim wrong");
    AST_SYNC: assert property (
        s_sync_run |-> alt_pin_level[7:0] == $past(bank_a_pins_in, 2))
        else $error("pin level latency wrong");
    AST_IRQ_HOLD: assert property (
        irq_req[0] && !irq_ack[0]
        && !(reg_wr && reg_addr == TBG_OFF_IRQ_POL) |=> irq_req[0])
        else $error("request dropped without clear");
endmodule // tbg_gpio_chk

bind tbg_gpio tbg_gpio_chk #(.BANK_C_PINS(BANK_C_PINS)) i_chk (
    .core_clk(core_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .bank_a_pins_in(bank_a_pins_in),
    .bank_a_pins_oe(bank_a_pins_oe),
    .bank_a_pull_en(bank_a_pull_en),
    .bank_a_p_drive_en(bank_a_p_drive_en),
    .bank_b_pins_out(bank_b_pins_out),
    .bank_b_pins_oe(bank_b_pins_oe),
    .bank_b_pull_en(bank_b_pull_en),
    .bank_b_p_drive_en(bank_b_p_drive_en),
    .bank_c_pins_oe(bank_c_pins_oe),
    .alt_claim(alt_claim),
    .alt_value(alt_value),
    .alt_push_pull(alt_push_pull),
    .alt_pin_level(alt_pin_level),
    .irq_ack(irq_ack),
    .irq_req(irq_req)
);

/* File: verif/tbg_board.sv */
// board model: external drivers, pull-ups and the pad wire of each pin.
// assumes drive enables, values and pull enables from the gpio core.
`timescale 1ns/10ps
module tbg_board (
    // clock
    input wire logic core_clk,
    // core side
    input wire logic [23:0] oe,
    input wire logic [23:0] out,
    input wire logic [23:0] pull,
    // board side
    input wire logic [23:0] ext_en,
    input wire logic [23:0] ext_val,
    output logic [23:0] level
);
    // ========================================
    // a pin nobody drives or pulls wanders, so a stale level never passes
    logic [23:0] drift_q = 24'h5a5a5a;
    always_ff @(posedge core_clk) begin
        drift_q <= ~drift_q;
    end
    assign level = (oe & out) | (~oe & ext_en & ext_val)
        | (~oe & ~ext_en & (pull | drift_q));
endmodule // tbg_board

/* File: verif/tb_tbg_gpio.sv */
// self-checking bench for the three-bank gpio core.
// assumes the board model on every pin and a plain register port.
`timescale 1ns/10ps
module tb_tbg_gpio import tbg_pkg::*;;
    // ========================================
    // stimulus and observation
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [23:0] oe, out, pull, pdrv, lvl, apl;
    logic [23:0] claim = 24'h0;
    logic [23:0] aval = 24'h0;
    logic [23:0] app = 24'h0;
    logic [23:0] ext_en = 24'hffffff;
    logic [23:0] ext_val = 24'h0;
    logic [1:0] irq_ack = 2'b00;
    logic [1:0] irq_req;
    logic rd_q = 1'b0;
    logic [7:0] expq[$];
    logic [7:0] base [3] = '{TBG_BASE_A, TBG_BASE_B, TBG_BASE_C};
    int errors = 0;
    int total_checks = 0;

    // bank c has six pins; the two absent ones are held quiet
    assign {oe[23:22], out[23:22], pull[23:22], pdrv[23:22]} = 8'h00;

    initial forever #50 core_clk = ~core_clk;

    tbg_gpio i_dut (
        .core_clk(core_clk),
        .srst(srst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .bank_a_pins_in(lvl[7:0]),
        .bank_a_pins_out(out[7:0]),
        .bank_a_pins_oe(oe[7:0]),
        .bank_a_pull_en(pull[7:0]),
        .bank_a_p_drive_en(pdrv[7:0]),
        .bank_b_pins_in(lvl[15:8]),
        .bank_b_pins_out(out[15:8]),
        .bank_b_pins_oe(oe[15:8]),
        .bank_b_pull_en(pull[15:8]),
        .bank_b_p_drive_en(pdrv[15:8]),
        .bank_c_pins_in(lvl[21:16]),
        .bank_c_pins_out(out[21:16]),
        .bank_c_pins_oe(oe[21:16]),
        .bank_c_pull_en(pull[21:16]),
        .bank_c_p_drive_en(pdrv[21:16]),
        .alt_claim(claim),
        .alt_value(aval),
        .alt_push_pull(app),
        .alt_pin_level(apl),
        .irq_ack(irq_ack),
        .irq_req(irq_req)
    );

    tbg_board i_board (
        .core_clk(core_clk),
        .oe(oe),
        .out(out),
        .pull(pull),
        .ext_en(ext_en),
        .ext_val(ext_val),
        .level(lvl)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // strobes stay up until the next call, so back to back never glitches
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic settle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // read data first stands in the cycle after the strobe and holds until the next read
    always @(posedge core_clk) rd_q <= reg_rd;
    always @(negedge core_clk) begin
        if (rd_q) begin
            chk(reg_rdata, expq.pop_front());
        end
    end

    initial begin
        #1000000;
        errors++;
        end_sim;
    end

    initial begin
        logic [7:0] d, v, m;
        void'($urandom(54));
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        for (int a = 0; a < 16; a++) begin
            rd(8'(a), 8'h00);
        end
        settle(0);
        chk(oe[7:0] | oe[15:8] | pull[15:8], 8'h00);
        $display("reset test done");
        for (int b = 0; b < 3; b++) begin
            m = (b == 2) ? 8'h3f : 8'hff;
            d = 8'($urandom);
            v = 8'($urandom);
            @(posedge core_clk);
            wr(base[b], d);
            wr(base[b] + TBG_SUB_MODE, 8'hff);
            settle(0);
            chk(pull[8*b+:8] & m, (b == 0) ? 8'h00 : m);
            @(posedge core_clk);
            wr(base[b] + TBG_SUB_DIR, m);
            rd(base[b], d & m);
            settle(0);
            chk(oe[8*b+:8] & m, (b == 0) ? ~d : m);
            chk(pdrv[8*b+:8] & m, (b == 0) ? 8'h00 : m);
            chk(out[8*b+:8] & oe[8*b+:8], (b == 0) ? 8'h00 : d & m);
            @(posedge core_clk);
            wr(base[b] + TBG_SUB_MODE, 8'h00);
            settle(0);
            chk(oe[8*b+:8] & m, ~d & m);
            @(posedge core_clk);
            wr(base[b] + TBG_SUB_DIR, 8'h00);
            ext_val[8*b+:8] <= v;
            settle(3);
            chk(apl[8*b+:8] & m, v & m);
            @(posedge core_clk);
            rd(base[b], v & m);
            settle(0);
        end
        $display("pin test done");
        @(posedge core_clk);
        aval <= 24'($urandom);
        claim <= 24'h00ffff;
        app <= 24'h00ff00;
        settle(0);
        chk(oe[7:0], ~aval[7:0]);
        chk(out[15:8] & oe[15:8] & pdrv[15:8], aval[15:8]);
        @(posedge core_clk);
        claim <= 24'h0;
        ext_val <= 24'hffffff;
        $display("alternate test done");
        settle(3);
        @(posedge core_clk);
        wr(TBG_BASE_A + TBG_SUB_MODE, 8'h03);
        wr(TBG_OFF_IRQ_POL, 8'h02);
        settle(3);
        chk({7'h0, irq_req[0]}, 8'h00);
        @(posedge core_clk);
        ext_val[0] <= 1'b0;
        settle(5);
        chk({7'h0, irq_req[0]}, 8'h01);
        @(posedge core_clk);
        // pin 1 falls as pin 0 rises: the anded group never sees an edge
        irq_ack <= 2'b01;
        ext_val[1:0] <= 2'b01;
        @(posedge core_clk);
        irq_ack <= 2'b00;
        settle(5);
        chk({7'h0, irq_req[0]}, 8'h00);
        @(posedge core_clk);
        ext_val[1] <= 1'b1;
        wr(TBG_BASE_A + TBG_SUB_DIR, 8'h01);
        ext_val[0] <= 1'b0;
        settle(5);
        chk({7'h0, irq_req[0]}, 8'h00);
        for (int p = 0; p < 4; p++) begin
            @(posedge core_clk);
            wr(TBG_OFF_IRQ_POL, 8'(p));
            ext_val[1] <= 1'b0;
            settle(5);
            chk({7'h0, irq_req[0]}, {7'h0, p != 1});
            @(posedge core_clk);
            irq_ack <= 2'b01;
            @(posedge core_clk);
            irq_ack <= 2'b00;
            ext_val[1] <= 1'b1;
            settle(5);
            chk({7'h0, irq_req[0]}, {7'h0, p != 2});
        end
        // group 1 kept its reset polarity, fall plus low, since the pin test
        chk({7'h0, irq_req[1]}, 8'h01);
        @(posedge core_clk);
        irq_ack <= 2'b10;
        @(posedge core_clk);
        irq_ack <= 2'b00;
        settle(1);
        chk({7'h0, irq_req[1]}, 8'h00);
        $display("interrupt test done");
        end_sim;
    end
endmodule // tb_tbg_gpio
